// ---- src/mst_pkg.sv ----
// package: constants, types and tables for the microstep translator and pwm regulator
package mst_pkg;

  // resolution encodings, {res_sel_hi, res_sel_lo}
  localparam logic [1:0] MST_RES_FULL = 2'h0;
  localparam logic [1:0] MST_RES_HALF = 2'h1;
  localparam logic [1:0] MST_RES_QTR = 2'h2;
  localparam logic [1:0] MST_RES_SIXT = 2'h3;

  // index increments per resolution, in sixteenth steps
  localparam logic [5:0] MST_INC_FULL = 6'h10;
  localparam logic [5:0] MST_INC_HALF = 6'h08;
  localparam logic [5:0] MST_INC_QTR = 6'h04;
  localparam logic [5:0] MST_INC_SIXT = 6'h01;

  // home index: 45 degree angle (sixteenth step number 9, zero based 8)
  localparam logic [5:0] MST_HOME_IDX = 6'h08;
  localparam logic [5:0] MST_IDX_ZERO = 6'h00;

  // clock and timing
  localparam int MST_CLK_MHZ = 200;
  localparam int MST_TOFF_NS = 38000;
  localparam int MST_TBLANK_NS = 950;
  localparam int MST_TOFF_CYC = (MST_TOFF_NS * MST_CLK_MHZ) / 1000;
  localparam int MST_TBLANK_CYC = (MST_TBLANK_NS * MST_CLK_MHZ + 999) / 1000;
  localparam int MST_TWAKE_US = 1000;
  localparam int MST_TWAKE_CYC = MST_TWAKE_US * MST_CLK_MHZ;

  // decay blend thresholds as 8-bit fraction of the logic supply (0.6 and 0.21)
  localparam logic [7:0] MST_PFD_HI = 8'h99;
  localparam logic [7:0] MST_PFD_LO = 8'h36;

  // decay modes
  typedef enum logic [1:0] {
    MST_DEC_SLOW = 2'b00,
    MST_DEC_FAST = 2'b01,
    MST_DEC_MIXED = 2'b10
  } mst_decay_t;

  // bridge switch pattern for one full bridge
  typedef struct packed {
    logic src_a;
    logic snk_a;
    logic src_b;
    logic snk_b;
  } mst_bridge_t;

  // fault group
  typedef struct packed {
    logic over_temp;
    logic pump_uv;
    logic gate_rail_fault;
    logic supply_lockout;
  } mst_fault_t;

  // phase level table, quarter wave of 17 entries, 8-bit magnitude of trip max
  function automatic logic [7:0] mst_sine(input logic [4:0] i);
    case (i)
      5'h00: mst_sine = 8'h00;
      5'h01: mst_sine = 8'h19;
      5'h02: mst_sine = 8'h32;
      5'h03: mst_sine = 8'h4A;
      5'h04: mst_sine = 8'h62;
      5'h05: mst_sine = 8'h78;
      5'h06: mst_sine = 8'h8E;
      5'h07: mst_sine = 8'hA2;
      5'h08: mst_sine = 8'hB4;
      5'h09: mst_sine = 8'hC5;
      5'h0A: mst_sine = 8'hD4;
      5'h0B: mst_sine = 8'hE1;
      5'h0C: mst_sine = 8'hEC;
      5'h0D: mst_sine = 8'hF4;
      5'h0E: mst_sine = 8'hFA;
      5'h0F: mst_sine = 8'hFE;
      default: mst_sine = 8'hFF;
    endcase
  endfunction : mst_sine

endpackage : mst_pkg

// ---- src/mst_pwm_bridge.sv ----
// one bridge: fixed off-time pwm regulator with blanking, mixed decay and rectification
`timescale 1ns/1ps
`default_nettype none
module mst_pwm_bridge
  import mst_pkg::*;
#(
  parameter int TOFF_CYC = mst_pkg::MST_TOFF_CYC,
  parameter int BLANK_CYC = mst_pkg::MST_TBLANK_CYC
) (
  // clock and control
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  // step side
  input wire logic polarity,
  input wire mst_pkg::mst_decay_t decay,
  input wire logic [7:0] blend_level,
  input wire logic step_evt,
  // analog side
  input wire logic sense_trip,
  input wire logic zero_current,
  input wire logic rectify_ctl,
  // outputs
  output mst_pkg::mst_bridge_t gates,
  output logic in_off
);
  import mst_pkg::*;

  localparam int CW = $clog2(TOFF_CYC + 1);
  localparam logic [CW-1:0] TOFF_C = CW'(TOFF_CYC); // see R26
  localparam logic [CW-1:0] BLANK_C = CW'(BLANK_CYC);
  localparam logic [CW-1:0] ZERO_C = '0;

  logic [CW-1:0] off_q;
  logic [CW-1:0] blank_q;
  logic zc_q;
  logic fast_phase;
  logic ramp_above;
  logic trip_ok;

  // ramp falls from 0.6 to 0 over off-time; compared with blend level
  assign ramp_above = (32'(off_q) * 32'(MST_PFD_HI)) > (32'(blend_level) * 32'(TOFF_CYC));
  assign trip_ok = run && (off_q == ZERO_C) && (blank_q == ZERO_C) && sense_trip; // see R12
  assign in_off = (off_q != ZERO_C);

  // one-shot off timer, per bridge
  always_ff @(posedge clk_sys) begin
    if (rst || (ce && !run)) begin
      off_q <= ZERO_C;
    end else if (ce) begin
      if (trip_ok) begin
        off_q <= TOFF_C; // see R11
      end else if (off_q != ZERO_C) begin
        off_q <= off_q - 1'b1;
      end
    end
  end

  // blanking restarts at each step event and at the end of each off-time
  always_ff @(posedge clk_sys) begin
    if (rst || (ce && !run)) begin
      blank_q <= BLANK_C;
    end else if (ce) begin
      if (step_evt || (off_q == CW'(1))) begin
        blank_q <= BLANK_C; // see R12
      end else if (blank_q != ZERO_C) begin
        blank_q <= blank_q - 1'b1;
      end
    end
  end

  // zero current latch, cleared at each new off cycle
  always_ff @(posedge clk_sys) begin
    if (rst || (ce && !run)) begin
      zc_q <= 1'b0;
    end else if (ce) begin
      // a detect in the trip cycle wins over the clear
      if (zero_current) begin
        zc_q <= 1'b1; // see R22
      end else if (trip_ok) begin
        zc_q <= 1'b0;
      end
    end
  end

  // fast portion: all of off-time in fast, ramp-bounded in mixed
  always_comb begin
    case (decay)
      MST_DEC_FAST: fast_phase = 1'b1;
      MST_DEC_MIXED: fast_phase = ramp_above; // see R21
      default: fast_phase = 1'b0;
    endcase
  end

  // gate pattern: drive diagonal, slow off = sources off with sinks recirculating
  always_ff @(posedge clk_sys) begin
    if (rst || (ce && !run)) begin
      gates <= '0;
    end else if (ce) begin
      if (off_q == ZERO_C && !trip_ok) begin
        gates <= polarity ? '{1'b1, 1'b0, 1'b0, 1'b1} : '{1'b0, 1'b1, 1'b1, 1'b0};
      end else if (fast_phase) begin
        // fast: source and sink off; without rectifier the diodes carry the decay
        if (rectify_ctl || zc_q) begin
          gates <= '0; // see R22 R23
        end else begin
          gates <= polarity ? '{1'b0, 1'b1, 1'b1, 1'b0} : '{1'b1, 1'b0, 1'b0, 1'b1}; // see R10
        end
      end else if (rectify_ctl || zc_q) begin
        // slow, no rectifier: the driving sink stays on, the other side is a diode
        gates <= polarity ? '{1'b0, 1'b0, 1'b0, 1'b1} : '{1'b0, 1'b1, 1'b0, 1'b0}; // see R23
      end else begin
        // slow: sources off, both sinks on
        gates <= '{1'b0, 1'b1, 1'b0, 1'b1}; // see R10
      end
    end
  end

  // assertions
  off_len_a: assert property (@(posedge clk_sys) disable iff (rst) // see R11
    (ce && trip_ok && run) |=> (off_q == TOFF_C))
    else $error("off timer not loaded on trip");
  blank_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // see R12
    (ce && run && blank_q != ZERO_C && off_q == ZERO_C) |=> (off_q == ZERO_C))
    else $error("trip accepted during blanking");
  rect_off_a: assert property (@(posedge clk_sys) disable iff (rst) // see R23
    (ce && run && rectify_ctl && off_q > CW'(1)) |=> (!gates.src_a && !gates.src_b
    && ($past(polarity) ? !gates.snk_a : !gates.snk_b)))
    else $error("rectification active while disabled");
  trip_c: cover property (@(posedge clk_sys) disable iff (rst) trip_ok);

endmodule : mst_pwm_bridge
`default_nettype wire

// ---- src/mst_translator.sv ----
// top: microstep translator, decay selection, protection and two pwm bridges
// Notes on behaviour
// R1: reset or power-on loads home position and mixed decay on both phases.
// R2: each rising advance_pulse moves one increment sized by the resolution inputs.
// R3: lo/hi select: 00 full, 10 half, 01 quarter, 11 sixteenth step.
// R4: resolution inputs are sampled only at the advance_pulse rising edge.
// R5: direction is sampled only at the advance_pulse rising edge.
// R6: falling level on a bridge takes decay from the blend level.
// R7: rising or equal level on a bridge takes slow decay.
// R8: reset low holds home, drivers off, and ignores step edges.
// R9: origin_flag shows home position, low while reset is held.
// R10: trip resets latch; slow turns sources off, fast (and the fast part of mixed) turns all off when not rectifying, else drives the reverse diagonal.
// R11: each bridge has a one-shot off timer after a trip.
// R12: comparator is ignored for a blanking time after output switching.
// R13: gate rail fault disables all drivers.
// R14: active-low enable turns drivers on when low, off when high.
// R15: translator keeps stepping regardless of enable.
// R16: overtemperature or pump rail undervoltage disables outputs while present.
// R17: supply lockout disables drivers and returns translator home.
// R18: sleep low disables drivers, regulator, pump; wake restarts from home.
// R19: controller waits 1 ms after wake before the first step.
// R20: blend above 0.6 gives slow, below 0.21 fast, between mixed.
// R21: mixed decay runs fast until ramp reaches blend level, then slow.
// R22: rectification on when control low, stopped at zero current.
// R23: rectification off when control high.
// R24: home is the 45 degree angle; direction high steps forward.
// R25: 64-entry sixteenth index moves by 16, 8, 4 or 1.
// R26: off, blank and fast times are counted in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module mst_translator
  import mst_pkg::*;
#(
  parameter int TOFF_CYC = mst_pkg::MST_TOFF_CYC,
  parameter int BLANK_CYC = mst_pkg::MST_TBLANK_CYC,
  parameter int WAKE_CYC = mst_pkg::MST_TWAKE_CYC
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // step interface
  input wire logic advance_pulse,
  input wire logic turn_sense,
  input wire logic res_sel_lo,
  input wire logic res_sel_hi,
  // control inputs
  input wire logic reset_n,
  input wire logic enable_n,
  input wire logic sleep_n,
  input wire logic rectify_ctl,
  input wire logic [7:0] decay_blend_level,
  input wire mst_pkg::mst_fault_t faults,
  // analog feedback per bridge
  input wire logic [1:0] sense_trip,
  input wire logic [1:0] zero_current,
  // outputs
  output logic origin_flag,
  output logic [7:0] level1,
  output logic [7:0] level2,
  output logic pol1,
  output logic pol2,
  output mst_pkg::mst_decay_t decay1,
  output mst_pkg::mst_decay_t decay2,
  output mst_pkg::mst_bridge_t gates1,
  output mst_pkg::mst_bridge_t gates2,
  output logic pump_on,
  output logic wake_ready
);
  import mst_pkg::*;

  localparam int WW = $clog2(WAKE_CYC + 1);
  localparam logic [WW-1:0] WAKE_C = WW'(WAKE_CYC);

  typedef enum logic [1:0] {
    MST_ST_HOLD = 2'b00,
    MST_ST_RUN = 2'b01
  } mst_state_t;

  mst_state_t state_q;
  logic [5:0] idx_q;
  logic [5:0] idx_d;
  logic pulse_q;
  logic step_evt;
  logic held;
  logic drv_on;
  logic [7:0] lvl1_d;
  logic [7:0] lvl2_d;
  logic [WW-1:0] wake_q;
  mst_bridge_t g1;
  mst_bridge_t g2;

  // step increment from the resolution inputs
  function automatic logic [5:0] mst_inc(input logic lo, input logic hi);
    case ({hi, lo})
      MST_RES_FULL: mst_inc = MST_INC_FULL; // see R3
      MST_RES_HALF: mst_inc = MST_INC_HALF;
      MST_RES_QTR: mst_inc = MST_INC_QTR;
      default: mst_inc = MST_INC_SIXT;
    endcase
  endfunction : mst_inc

  // magnitude of sine at index, using quarter-wave symmetry
  function automatic logic [7:0] mst_mag(input logic [5:0] i);
    logic [4:0] q;
    q = {1'b0, i[3:0]};
    if (i[4]) begin
      mst_mag = mst_sine(5'h10 - q);
    end else begin
      mst_mag = mst_sine(q);
    end
  endfunction : mst_mag

  // decay pick for a level change
  function automatic mst_decay_t mst_pick(input logic [7:0] nw, input logic [7:0] od,
                                          input logic [7:0] blend);
    if (nw >= od) begin
      mst_pick = MST_DEC_SLOW; // see R7
    end else if (blend > MST_PFD_HI) begin
      mst_pick = MST_DEC_SLOW; // see R6 R20
    end else if (blend < MST_PFD_LO) begin
      mst_pick = MST_DEC_FAST; // see R20
    end else begin
      mst_pick = MST_DEC_MIXED;
    end
  endfunction : mst_pick

  // translator held home by reset, lockout or sleep
  assign held = !reset_n || faults.supply_lockout || !sleep_n; // see R8 R17 R18
  // driver enable ignores enable for stepping but gates outputs
  assign drv_on = !held && !enable_n && !faults.gate_rail_fault // see R13 R14
                  && !faults.over_temp && !faults.pump_uv; // see R16
  assign step_evt = ce && advance_pulse && !pulse_q && (state_q == MST_ST_RUN) && !held;

  // next index: direction and resolution sampled at the edge only
  always_comb begin
    if (turn_sense) begin
      idx_d = idx_q + mst_inc(res_sel_lo, res_sel_hi); // see R2 R4 R5 R24 R25
    end else begin
      idx_d = idx_q - mst_inc(res_sel_lo, res_sel_hi);
    end
    lvl1_d = mst_mag(idx_d + 6'h10); // cosine
    lvl2_d = mst_mag(idx_d);
  end

  // step edge detector; input taken as synchronous
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pulse_q <= 1'b0;
    end else if (ce) begin
      pulse_q <= advance_pulse;
    end
  end

  // state: hold while held, run otherwise
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= MST_ST_HOLD;
    end else if (ce) begin
      case (state_q)
        MST_ST_HOLD: state_q <= held ? MST_ST_HOLD : MST_ST_RUN;
        MST_ST_RUN: state_q <= held ? MST_ST_HOLD : MST_ST_RUN;
        default: state_q <= MST_ST_HOLD;
      endcase
    end
  end

  // position, levels, polarity and decay
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      idx_q <= MST_HOME_IDX; // see R1
      level1 <= mst_mag(MST_HOME_IDX + 6'h10);
      level2 <= mst_mag(MST_HOME_IDX);
      pol1 <= 1'b1;
      pol2 <= 1'b1;
      decay1 <= MST_DEC_MIXED;
      decay2 <= MST_DEC_MIXED;
    end else if (ce) begin
      if (held) begin
        idx_q <= MST_HOME_IDX; // see R8 R17 R18
        level1 <= mst_mag(MST_HOME_IDX + 6'h10);
        level2 <= mst_mag(MST_HOME_IDX);
        pol1 <= 1'b1;
        pol2 <= 1'b1;
        decay1 <= MST_DEC_MIXED;
        decay2 <= MST_DEC_MIXED;
      end else if (step_evt) begin
        idx_q <= idx_d; // see R15
        level1 <= lvl1_d;
        level2 <= lvl2_d;
        pol1 <= ((idx_d + 6'h10) < 6'h20) || (lvl1_d == 8'h00);
        pol2 <= (idx_d < 6'h20) || (lvl2_d == 8'h00);
        decay1 <= mst_pick(lvl1_d, level1, decay_blend_level); // see R6
        decay2 <= mst_pick(lvl2_d, level2, decay_blend_level);
      end
    end
  end

  // home indicator
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      origin_flag <= 1'b0;
    end else if (ce) begin
      origin_flag <= reset_n && ((held ? MST_HOME_IDX : (step_evt ? idx_d : idx_q))
                     == MST_HOME_IDX); // see R9
    end
  end

  // wake timer; charge pump settles, informs that steps are welcome
  always_ff @(posedge clk_sys) begin
    if (rst || (ce && !sleep_n)) begin
      wake_q <= WAKE_C;
    end else if (ce && wake_q != '0) begin
      wake_q <= wake_q - 1'b1;
    end
  end
  assign wake_ready = (wake_q == '0); // see R19
  assign pump_on = sleep_n;

  // per-bridge regulators
  mst_pwm_bridge #(.TOFF_CYC(TOFF_CYC), .BLANK_CYC(BLANK_CYC)) u_br1 (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .run(drv_on),
    .polarity(pol1),
    .decay(decay1),
    .blend_level(decay_blend_level),
    .step_evt(step_evt),
    .sense_trip(sense_trip[0]),
    .zero_current(zero_current[0]),
    .rectify_ctl(rectify_ctl),
    .gates(g1),
    .in_off()
  );
  mst_pwm_bridge #(.TOFF_CYC(TOFF_CYC), .BLANK_CYC(BLANK_CYC)) u_br2 (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .run(drv_on),
    .polarity(pol2),
    .decay(decay2),
    .blend_level(decay_blend_level),
    .step_evt(step_evt),
    .sense_trip(sense_trip[1]),
    .zero_current(zero_current[1]),
    .rectify_ctl(rectify_ctl),
    .gates(g2),
    .in_off()
  );
  // gating is immediate so a fault cuts drive without a clock of delay
  assign gates1 = drv_on ? g1 : '0; // see R13 R14 R16
  assign gates2 = drv_on ? g2 : '0;

  // assertions
  home_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // see R8
    (ce && !reset_n) |=> (idx_q == MST_HOME_IDX && !origin_flag))
    else $error("reset low did not hold home");
  drv_off_a: assert property (@(posedge clk_sys) disable iff (rst) // see R14
    enable_n |-> (gates1 == '0 && gates2 == '0))
    else $error("drivers on while disabled");
  fault_off_a: assert property (@(posedge clk_sys) disable iff (rst) // see R16
    (faults.over_temp || faults.pump_uv || faults.gate_rail_fault) |-> (gates1 == '0))
    else $error("drivers on during fault");
  step_move_a: assert property (@(posedge clk_sys) disable iff (rst) // see R2
    step_evt |=> (idx_q == $past(idx_d)))
    else $error("step did not advance index");
  hold_idx_a: assert property (@(posedge clk_sys) disable iff (rst) // see R4
    (ce && !step_evt && !held) |=> (idx_q == $past(idx_q)))
    else $error("index moved without step");
  slow_rise_a: assert property (@(posedge clk_sys) disable iff (rst) // see R7
    (step_evt && lvl1_d >= level1) |=> (decay1 == MST_DEC_SLOW))
    else $error("rising level not slow decay");
  lockout_home_a: assert property (@(posedge clk_sys) disable iff (rst) // see R17
    (ce && faults.supply_lockout) |=> (idx_q == MST_HOME_IDX && gates1 == '0))
    else $error("lockout did not home");
  sleep_off_a: assert property (@(posedge clk_sys) disable iff (rst) // see R18
    !sleep_n |-> (!pump_on && gates2 == '0))
    else $error("sleep left drivers on");
  step_c: cover property (@(posedge clk_sys) disable iff (rst) step_evt);
  back_c: cover property (@(posedge clk_sys) disable iff (rst) step_evt && !turn_sense);
  mixed_c: cover property (@(posedge clk_sys) disable iff (rst) step_evt ##1 decay2 == MST_DEC_MIXED);

endmodule : mst_translator
`default_nettype wire

// ---- bench/mst_step_ctl.sv ----
// partner model: step-pulse controller feeding the translator's step lines
`timescale 1ns/1ps
`default_nettype none
module mst_step_ctl #(
  parameter int WAKE_CYC = 50
) (
  // clock and wake watch
  input wire logic clk_sys,
  input wire logic sleep_n,
  // step lines
  output logic advance_pulse,
  output logic turn_sense,
  output logic res_sel_lo,
  output logic res_sel_hi,
  // high for the cycle after a pulse was sampled
  output logic step_done
);
  int wake_cnt;

  initial begin
    advance_pulse = 1'b0;
    turn_sense = 1'b0;
    res_sel_lo = 1'b0;
    res_sel_hi = 1'b0;
    step_done = 1'b0;
    wake_cnt = 0;
  end

  // cycles since wake; steps wait until the gate supply has settled
  always @(posedge clk_sys) begin
    if (!sleep_n) begin
      wake_cnt <= 0;
    end else if (wake_cnt < WAKE_CYC) begin
      wake_cnt <= wake_cnt + 1;
    end
  end

  // one step: levels set a cycle ahead, pulse high one cycle, then low
  task automatic step(input logic d, input logic [1:0] r);
    while (wake_cnt < WAKE_CYC) @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
    turn_sense = d;
    res_sel_lo = r[0];
    res_sel_hi = r[1];
    @(posedge clk_sys);
    #1;
    advance_pulse = 1'b1;
    @(posedge clk_sys);
    #1;
    advance_pulse = 1'b0;
    step_done = 1'b1;
    // past the hold time the levels wander; the translator must not care
    turn_sense = ~d;
    res_sel_lo = ~r[0];
    res_sel_hi = ~r[1];
    @(posedge clk_sys);
    #1;
    step_done = 1'b0;
  endtask : step
endmodule : mst_step_ctl
`default_nettype wire

// ---- bench/mst_translator_tb.sv ----
// testbench: stepping, decay choice, hold states and drive gating of the translator
`timescale 1ns/1ps
`default_nettype none
module mst_translator_tb;
  import mst_pkg::*;
  localparam int TOFF = 20;
  localparam int BLANK = 4;
  localparam int WAKE = 50;
  // vector: origin, levels, pols | decays | pump, any drive, gates
  localparam logic [33:0] MK_POS = 34'h3FFFF8000;
  localparam logic [33:0] MK_DEC = 34'h000007800;
  localparam logic [33:0] MK_DRV = 34'h0000007FF;
  typedef struct packed {
    logic [33:0] e;
    logic [33:0] m;
  } mst_note_t;
  logic [7:0] sine_tab [17] = '{8'h00, 8'h19, 8'h32, 8'h4A, 8'h62, 8'h78, 8'h8E, 8'hA2,
    8'hB4, 8'hC5, 8'hD4, 8'hE1, 8'hEC, 8'hF4, 8'hFA, 8'hFE, 8'hFF};
  logic [7:0] blends [8] = '{8'h00, 8'h35, 8'h36, 8'h80, 8'h99, 8'h9A, 8'hFF, 8'h20};
  logic clk_sys, rst, ce, reset_n, enable_n, sleep_n, rectify_ctl, probe;
  logic advance_pulse, turn_sense, res_sel_lo, res_sel_hi, step_done;
  logic [7:0] decay_blend_level;
  mst_fault_t faults;
  logic [1:0] sense_trip, zero_current;
  logic origin_flag, pol1, pol2, pump_on, wake_ready;
  logic [7:0] level1, level2;
  mst_decay_t decay1, decay2, dm1, dm2;
  mst_bridge_t gates1, gates2;
  logic [33:0] outv;
  logic [5:0] idx;
  // gate bytes that the pwm checks expect
  logic [7:0] gexp;
  mst_note_t notes [$];
  mst_note_t cur;
  logic [31:0] rv;
  integer errors, compares, seed, cyc, k;

  mst_translator #(.TOFF_CYC(TOFF), .BLANK_CYC(BLANK), .WAKE_CYC(WAKE)) uut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .advance_pulse(advance_pulse),
    .turn_sense(turn_sense), .res_sel_lo(res_sel_lo), .res_sel_hi(res_sel_hi),
    .reset_n(reset_n), .enable_n(enable_n), .sleep_n(sleep_n), .rectify_ctl(rectify_ctl),
    .decay_blend_level(decay_blend_level), .faults(faults), .sense_trip(sense_trip),
    .zero_current(zero_current), .origin_flag(origin_flag), .level1(level1),
    .level2(level2), .pol1(pol1), .pol2(pol2), .decay1(decay1), .decay2(decay2),
    .gates1(gates1), .gates2(gates2), .pump_on(pump_on), .wake_ready(wake_ready));

  mst_step_ctl #(.WAKE_CYC(WAKE)) ctl (
    .clk_sys(clk_sys), .sleep_n(sleep_n), .advance_pulse(advance_pulse),
    .turn_sense(turn_sense), .res_sel_lo(res_sel_lo), .res_sel_hi(res_sel_hi),
    .step_done(step_done));

  assign outv = {origin_flag, level1, level2, pol1, pol2, decay1, decay2, pump_on,
    |gates1, |gates2, gates1, gates2};

  always #2.5 clk_sys = ~clk_sys;

  // magnitude of sin(i); cos is the same index moved a quarter turn
  function automatic logic [7:0] mag(input logic [5:0] i);
    mag = i[4] ? sine_tab[5'h10 - {1'b0, i[3:0]}] : sine_tab[{1'b0, i[3:0]}];
  endfunction : mag

  function automatic mst_decay_t pick(input logic [7:0] b);
    pick = (b > MST_PFD_HI) ? MST_DEC_SLOW : (b < MST_PFD_LO) ? MST_DEC_FAST : MST_DEC_MIXED;
  endfunction : pick

  task automatic chk(input logic [33:0] act, input logic [33:0] exp);
    compares = compares + 1;
    if (act !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : chk

  // queue the model's view; polarity of a zero level is left open
  task automatic note(input logic org, input logic pmp, input logic anyg, input logic [33:0] m);
    logic [5:0] j;
    j = idx + 6'h10;
    if (mag(j) == 8'h00) m[16] = 1'b0;
    if (mag(idx) == 8'h00) m[15] = 1'b0;
    notes.push_back('{{org & (idx == MST_HOME_IDX), mag(j), mag(idx), ~j[5], ~idx[5],
      dm1, dm2, pmp, anyg, anyg, gexp}, m});
  endtask : note

  task automatic look(input logic org, input logic pmp, input logic anyg, input logic [33:0] m);
    note(org, pmp, anyg, m);
    probe = 1'b1;
    @(posedge clk_sys);
    #1;
    probe = 1'b0;
  endtask : look

  task automatic step(input logic d, input logic [1:0] r, input logic live,
                      input logic [33:0] m);
    logic [7:0] o1;
    logic [7:0] o2;
    logic [5:0] inc;
    inc = (r == MST_RES_FULL) ? MST_INC_FULL : (r == MST_RES_HALF) ? MST_INC_HALF :
      (r == MST_RES_QTR) ? MST_INC_QTR : MST_INC_SIXT;
    if (live) begin
      o1 = mag(idx + 6'h10);
      o2 = mag(idx);
      idx = d ? idx + inc : idx - inc;
      dm1 = (mag(idx + 6'h10) < o1) ? pick(decay_blend_level) : MST_DEC_SLOW;
      dm2 = (mag(idx) < o2) ? pick(decay_blend_level) : MST_DEC_SLOW;
    end
    note(live, 1'b1, ~enable_n & reset_n, m);
    ctl.step(d, r);
  endtask : step

  task automatic results;
    $display("counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // watcher: oldest note against the outputs whenever a result is due
  always @(posedge clk_sys) begin
    if (step_done === 1'b1 || probe === 1'b1) begin
      cur = notes.pop_front();
      chk(outv & cur.m, cur.e & cur.m);
    end
  end

  // hang guard, far above the roughly five hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      errors = errors + 1;
      results();
    end
  end

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    reset_n = 1'b1;
    enable_n = 1'b0;
    sleep_n = 1'b1;
    rectify_ctl = 1'b1;
    decay_blend_level = 8'h80;
    faults = '0;
    sense_trip = 2'h0;
    zero_current = 2'h0;
    probe = 1'b0;
    errors = 0;
    compares = 0;
    seed = 50147;
    cyc = 0;
    idx = MST_HOME_IDX;
    dm1 = MST_DEC_MIXED;
    dm2 = MST_DEC_MIXED;
    gexp = 8'h00;
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    look(1'b1, 1'b1, 1'b1, MK_POS | MK_DEC | 34'h700);
    $display("test home done");
    // every resolution twice first in random directions, then random moves and blend levels
    for (k = 0; k < 48; k++) begin
      rv = $random(seed);
      decay_blend_level = blends[rv[5:3]];
      step(rv[0], (k < 8) ? k[1:0] : rv[2:1], 1'b1, MK_POS | MK_DEC);
    end
    repeat (5) @(posedge clk_sys);
    #1;
    look(1'b1, 1'b1, 1'b1, MK_POS | MK_DEC);
    $display("test stepping done");
    reset_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    idx = MST_HOME_IDX;
    dm1 = MST_DEC_MIXED;
    dm2 = MST_DEC_MIXED;
    look(1'b0, 1'b1, 1'b0, MK_POS | MK_DEC | MK_DRV);
    step(1'b1, MST_RES_FULL, 1'b0, MK_POS | MK_DEC | MK_DRV);
    reset_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    look(1'b1, 1'b1, 1'b1, MK_POS | MK_DEC | 34'h700);
    enable_n = 1'b1;
    step(1'b0, MST_RES_SIXT, 1'b1, MK_POS | MK_DEC | MK_DRV);
    enable_n = 1'b0;
    $display("test reset and enable done");
    // each fault in turn blocks the drive; lockout also sends the index home
    for (k = 0; k < 4; k++) begin
      step(1'b1, MST_RES_SIXT, 1'b1, MK_POS);
      faults = 4'h1 << k;
      repeat (2) @(posedge clk_sys);
      #1;
      if (k == 0) idx = MST_HOME_IDX;
      look(1'b0, 1'b1, 1'b0, MK_DRV | ((k == 0) ? 34'h1FFFF8000 : 34'h0));
      faults = '0;
      repeat (TOFF + BLANK) @(posedge clk_sys);
      #1;
      look(1'b1, 1'b1, 1'b1, 34'h300);
    end
    $display("test faults done");
    // clock enable low: the pulse meets no live edge, nothing moves
    ce = 1'b0;
    step(1'b1, MST_RES_FULL, 1'b0, MK_POS | MK_DEC);
    ce = 1'b1;
    step(1'b1, MST_RES_HALF, 1'b1, MK_POS);
    sleep_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    look(1'b1, 1'b0, 1'b0, MK_DRV);
    sleep_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    idx = MST_HOME_IDX;
    look(1'b1, 1'b1, 1'b1, MK_POS);
    step(1'b1, MST_RES_FULL, 1'b1, MK_POS | MK_DEC);
    $display("test sleep done");
    // a trip inside the blanking window after a step is ignored
    sense_trip = 2'h1;
    @(posedge clk_sys);
    #1;
    sense_trip = 2'h0;
    look(1'b1, 1'b1, 1'b1, 34'h200);
    repeat (BLANK + 4) @(posedge clk_sys);
    #1;
    sense_trip = 2'h1;
    @(posedge clk_sys);
    #1;
    sense_trip = 2'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    // slow decay, rectifier off, negative phase: only the sink on side a stays on
    gexp = 8'h40;
    look(1'b1, 1'b1, 1'b1, 34'h2F0);
    repeat (TOFF - 6) @(posedge clk_sys);
    #1;
    look(1'b1, 1'b1, 1'b1, 34'h2F0);
    repeat (BLANK + 6) @(posedge clk_sys);
    #1;
    look(1'b1, 1'b1, 1'b1, 34'h200);
    // rectifier on: both sinks recirculate until zero current is seen
    rectify_ctl = 1'b0;
    sense_trip = 2'h1;
    @(posedge clk_sys);
    #1;
    sense_trip = 2'h0;
    gexp = 8'h50;
    look(1'b1, 1'b1, 1'b1, 34'h2F0);
    zero_current = 2'h1;
    repeat (2) @(posedge clk_sys);
    #1;
    zero_current = 2'h0;
    gexp = 8'h40;
    look(1'b1, 1'b1, 1'b1, 34'h2F0);
    $display("test pwm done");
    results();
  end
endmodule : mst_translator_tb
`default_nettype wire
